// >>> hdl/amr_top.sv
// analog monitor readout: conversion sequencer, limits, flags, buffers, bus and link
//
// Design decisions made here: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ns
module amr_top #(
  parameter int FRAME_CYC = amr_pkg::FRAME_TYP_CYC
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // converter
  output amr_pkg::amr_conv_req_t conv_req,
  input wire amr_pkg::amr_conv_rsp_t conv_rsp,
  // buffers and interrupt
  input wire logic buffer_logic_input_a,
  input wire logic buffer_logic_input_b,
  output logic fault_buffer_output_a_oe,
  output logic fault_buffer_output_b_oe,
  output logic monitor_irq,
  // serial link
  input wire logic link_clk,
  input wire logic link_frame_n,
  input wire logic link_sdi,
  output logic link_sdo_oe
);
  import amr_pkg::*;

  // assertions below, generate loops included, run on the bus clock, except the two link assertions, which run on link_clk
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  if (FRAME_CYC < 2 || FRAME_CYC > FRAME_MAX_CYC) begin : g_bad_frame
    $error("frame period outside the supported range");
  end

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_START = 2'b01,
    ST_WAIT = 2'b10
  } amr_conv_state_t;

  function automatic logic [15:0] lim_rst(int c, int k);
    logic hi;
    hi = (k == K_ALARM_HI) || (k == K_WARN_HI);
    if (c == int'(CH_TEMP)) begin
      lim_rst = hi ? LIM_HI_SGN : LIM_LO_SGN;
    end else begin
      lim_rst = hi ? LIM_HI_UNS : LIM_LO_UNS;
    end
  endfunction

  // bus state
  logic pend_reg, wr_reg, addr_ok_reg;
  logic [7:0] addr_reg;
  logic [31:0] hrdata_reg, rd_mux;
  logic hreadyout_reg, hresp_reg;
  // block state
  logic [NUM_CH-1:0] int_en_reg, done_reg;
  logic fault_en_reg;
  logic [NUM_CH-1:0] flag_reg [LIM_KINDS];
  logic [15:0] result_reg [NUM_CH];
  logic [15:0] limit_reg [NUM_CH][LIM_KINDS];
  amr_conv_state_t st_reg;
  logic [2:0] chan_reg;
  amr_conv_req_t conv_req_reg;
  logic [31:0] frame_cnt_reg;
  logic in_a_s1_reg, in_a_s2_reg, in_b_s1_reg, in_b_s2_reg;
  logic fault_a_reg, fault_b_reg, irq_reg;
  // crossing state
  logic [15:0] shadow_reg [NUM_CH+1];
  logic pub_reg, ack_s1_reg, ack_s2_reg;
  logic pub_s1_reg, pub_s2_reg, seen_reg;
  logic [15:0] bank_reg [NUM_CH+1];
  logic [4:0] bit_cnt_reg;
  logic [6:0] cmd_reg;
  logic [15:0] out_reg, sel_word;
  logic sdo_oe_reg;

  wire take = hsel && htrans[1] && hready;
  wire wr_fire = pend_reg && wr_reg && addr_ok_reg;
  wire is_res = (addr_reg[7:5] == ADDR_RESULT_BASE[7:5]) && (addr_reg[4:2] < 3'(NUM_CH));
  wire is_lim = (addr_reg >= ADDR_LIMIT_BASE) && (addr_reg < ADDR_LIMIT_END);
  wire [2:0] lim_ch = 3'(addr_reg[7:4] - ADDR_LIMIT_BASE[7:4]);
  wire [1:0] lim_k = addr_reg[3:2];
  wire res_we = (st_reg == ST_WAIT) && conv_rsp.done;
  wire frame_tick = (frame_cnt_reg == 32'h0000_0000);
  wire [NUM_CH-1:0] done_set;
  wire [NUM_CH-1:0] cond [LIM_KINDS];
  wire [NUM_CH-1:0] alarm_any = flag_reg[K_ALARM_HI] | flag_reg[K_ALARM_LO];
  wire [NUM_CH-1:0] warn_any = flag_reg[K_WARN_HI] | flag_reg[K_WARN_LO];
  wire [NUM_CH-1:0] any_flag = alarm_any | warn_any;
  wire [15:0] status_word = {1'b0, done_reg, alarm_any, warn_any};
  wire link_rst_n = hresetn && !link_frame_n;
  wire [7:0] cmd_full = {cmd_reg, link_sdi};

  assign hrdata = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  assign hresp = hresp_reg;
  assign conv_req = conv_req_reg;
  assign fault_buffer_output_a_oe = fault_a_reg;
  assign fault_buffer_output_b_oe = fault_b_reg;
  assign monitor_irq = irq_reg;
  assign link_sdo_oe = sdo_oe_reg;

  // address phase capture, one wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_reg <= 1'b0;
      wr_reg <= 1'b0;
      addr_ok_reg <= 1'b0;
      addr_reg <= 8'h00;
      hrdata_reg <= 32'h0000_0000;
      hreadyout_reg <= 1'b1;
      hresp_reg <= 1'b0;
    end else begin
      hresp_reg <= 1'b0;
      if (pend_reg) begin
        pend_reg <= 1'b0;
        hreadyout_reg <= 1'b1;
        if (!wr_reg) begin
          hrdata_reg <= rd_mux;
        end
      end else if (take) begin
        pend_reg <= 1'b1;
        wr_reg <= hwrite;
        addr_reg <= haddr[7:0];
        addr_ok_reg <= (haddr[31:8] == 24'h00_0000) && (haddr[1:0] == 2'h0) && (hsize == HSIZE_WORD);
        hreadyout_reg <= 1'b0;
      end
    end
  end

  // read data select, unmapped reads zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (addr_ok_reg) begin
      if (addr_reg == ADDR_CTRL) begin
        rd_mux[NUM_CH-1:0] = int_en_reg;
        rd_mux[CTRL_FAULT_EN_BIT] = fault_en_reg;
      end else if (addr_reg == ADDR_DONE) begin
        rd_mux[NUM_CH-1:0] = done_reg;
      end else if (addr_reg == ADDR_FLAGS) begin
        for (int k = 0; k < LIM_KINDS; k++) begin
          rd_mux[FLAG_STRIDE*k +: NUM_CH] = flag_reg[k];
        end
      end else if (is_res) begin
        rd_mux[15:0] = result_reg[addr_reg[4:2]];
      end else if (is_lim) begin
        rd_mux[15:0] = limit_reg[lim_ch][lim_k];
      end
    end
  end

  // control register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_en_reg <= '0;
      fault_en_reg <= 1'b0;
    end else if (wr_fire && addr_reg == ADDR_CTRL) begin
      int_en_reg <= hwdata[NUM_CH-1:0];
      fault_en_reg <= hwdata[CTRL_FAULT_EN_BIT];
    end
  end

  // limit registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int c = 0; c < NUM_CH; c++) begin
        for (int k = 0; k < LIM_KINDS; k++) begin
          limit_reg[c][k] <= lim_rst(c, k);
        end
      end
    end else if (wr_fire && is_lim) begin
      limit_reg[lim_ch][lim_k] <= hwdata[15:0];
    end
  end

  // frame timer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frame_cnt_reg <= 32'h0000_0000;
    end else if (frame_tick) begin
      frame_cnt_reg <= 32'(FRAME_CYC - 1);
    end else begin
      frame_cnt_reg <= frame_cnt_reg - 32'h0000_0001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= ST_IDLE;
      chan_reg <= CH_TEMP;
      conv_req_reg <= '0;
    end else begin
      case (st_reg)
        ST_IDLE: begin
          conv_req_reg.start <= 1'b0;
          if (frame_tick) begin
            chan_reg <= CH_TEMP;
            st_reg <= ST_START;
          end
        end
        ST_START: begin
          conv_req_reg.start <= 1'b1;
          conv_req_reg.chan <= chan_reg;
          st_reg <= ST_WAIT;
        end
        ST_WAIT: begin
          conv_req_reg.start <= 1'b0;
          if (conv_rsp.done) begin
            if (chan_reg == CH_EXT_C) begin
              st_reg <= ST_IDLE;
            end else begin
              chan_reg <= chan_reg + 3'h1;
              st_reg <= ST_START;
            end
          end
        end
        default: st_reg <= ST_IDLE;
      endcase
    end
  end

  // result capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int c = 0; c < NUM_CH; c++) begin
        result_reg[c] <= 16'h0000;
      end
    end else if (res_we) begin
      result_reg[chan_reg] <= conv_rsp.data & RESULT_MASK;
    end
  end

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    assign done_set[c] = res_we && (chan_reg == 3'(c));
    for (genvar k = 0; k < LIM_KINDS; k++) begin : g_kind
      localparam bit SGN = (c == int'(CH_TEMP));
      localparam bit HI = (k == K_ALARM_HI) || (k == K_WARN_HI);
      wire above = SGN ? ($signed(result_reg[c]) > $signed(limit_reg[c][k])) : (result_reg[c] > limit_reg[c][k]);
      wire below = SGN ? ($signed(result_reg[c]) < $signed(limit_reg[c][k])) : (result_reg[c] < limit_reg[c][k]);
      assign cond[k][c] = HI ? above : below;
      a_flag_follows: assert property (cond[k][c] |=> flag_reg[k][c])
        else $error("limit flag not set after out-of-limit");
    end
    a_low_bits_zero: assert property (result_reg[c][2:0] == 3'h0)
      else $error("result low bits not zero");
  end

  // done bits, set wins over clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_reg <= '0;
    end else begin
      done_reg <= (done_reg & ~((wr_fire && addr_reg == ADDR_DONE) ? hwdata[NUM_CH-1:0] : '0)) | done_set;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int k = 0; k < LIM_KINDS; k++) begin
        flag_reg[k] <= '0;
      end
    end else begin
      for (int k = 0; k < LIM_KINDS; k++) begin
        flag_reg[k] <= (flag_reg[k] & ~((wr_fire && addr_reg == ADDR_FLAGS) ? hwdata[FLAG_STRIDE*k +: NUM_CH] : '0))
          | cond[k];
      end
    end
  end

  // buffer input synchronisers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      in_a_s1_reg <= 1'b1;
      in_a_s2_reg <= 1'b1;
      in_b_s1_reg <= 1'b1;
      in_b_s2_reg <= 1'b1;
    end else begin
      in_a_s1_reg <= buffer_logic_input_a;
      in_a_s2_reg <= in_a_s1_reg;
      in_b_s1_reg <= buffer_logic_input_b;
      in_b_s2_reg <= in_b_s1_reg;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fault_a_reg <= 1'b0;
      fault_b_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      fault_a_reg <= !in_a_s2_reg || (fault_en_reg && (|alarm_any));
      fault_b_reg <= !in_b_s2_reg;
      irq_reg <= |(any_flag & int_en_reg);
    end
  end

  // publish snapshot once the link has taken the last one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pub_reg <= 1'b0;
      ack_s1_reg <= 1'b0;
      ack_s2_reg <= 1'b0;
      for (int i = 0; i <= NUM_CH; i++) begin
        shadow_reg[i] <= 16'h0000;
      end
    end else begin
      ack_s1_reg <= seen_reg;
      ack_s2_reg <= ack_s1_reg;
      if (ack_s2_reg == pub_reg) begin
        for (int i = 0; i < NUM_CH; i++) begin
          shadow_reg[i] <= result_reg[i];
        end
        shadow_reg[CMD_STATUS] <= status_word;
        pub_reg <= !pub_reg;
      end
    end
  end

  // link side copy of the snapshot
  always_ff @(posedge link_clk or negedge hresetn) begin
    if (!hresetn) begin
      pub_s1_reg <= 1'b0;
      pub_s2_reg <= 1'b0;
      seen_reg <= 1'b0;
      for (int i = 0; i <= NUM_CH; i++) begin
        bank_reg[i] <= 16'h0000;
      end
    end else begin
      pub_s1_reg <= pub_reg;
      pub_s2_reg <= pub_s1_reg;
      if (pub_s2_reg != seen_reg) begin
        seen_reg <= pub_s2_reg;
        bank_reg <= shadow_reg;
      end
    end
  end

  always_comb begin
    sel_word = 16'h0000;
    if (cmd_full[7:3] == 5'h00 && cmd_full[2:0] <= CMD_STATUS) begin
      sel_word = bank_reg[cmd_full[2:0]];
    end
  end

  // command in, word out high byte first
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      bit_cnt_reg <= 5'h00;
      cmd_reg <= 7'h00;
      out_reg <= 16'h0000;
      sdo_oe_reg <= 1'b0;
    end else if (bit_cnt_reg < LINK_LOAD_CNT) begin
      cmd_reg <= cmd_full[6:0];
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
    end else if (bit_cnt_reg == LINK_LOAD_CNT) begin
      out_reg <= sel_word;
      sdo_oe_reg <= !sel_word[15];
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
    end else if (bit_cnt_reg < LINK_LAST_CNT) begin
      out_reg <= {out_reg[14:0], 1'b0};
      sdo_oe_reg <= !out_reg[14];
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
    end else begin
      sdo_oe_reg <= 1'b0;
    end
  end

  sequence s_addr_taken;
    hsel && htrans[1] && hready;
  endsequence
  sequence s_one_wait;
    !hreadyout ##1 hreadyout;
  endsequence

  a_bus_one_wait: assert property (s_addr_taken |=> s_one_wait)
    else $error("bus transfer did not take exactly one wait state");
  a_done_on_result: assert property (res_we |=> done_reg[$past(chan_reg)])
    else $error("done bit not set after new result");
  a_result_format: assert property (res_we |=> result_reg[$past(chan_reg)] == ($past(conv_rsp.data) & RESULT_MASK))
    else $error("result not stored left-justified and masked");
  a_round_robin: assert property (res_we && chan_reg != CH_EXT_C |=> st_reg == ST_START && chan_reg == $past(chan_reg) + 3'h1)
    else $error("channel order broken");
  a_frame_start: assert property (st_reg == ST_IDLE && frame_tick |=> st_reg == ST_START && chan_reg == CH_TEMP)
    else $error("frame did not start a round at temperature");
  a_irq_follows: assert property (|(any_flag & int_en_reg) |=> monitor_irq)
    else $error("interrupt indication missing for enabled channel");
  a_fault_alarm: assert property (fault_en_reg && (|alarm_any) |=> fault_buffer_output_a_oe)
    else $error("fault output not driven on alarm");
  a_buffer_pass: assert property (!buffer_logic_input_b ##2 !in_b_s2_reg |=> fault_buffer_output_b_oe)
    else $error("buffer b did not pass a low input");
  a_link_quiet: assert property (@(posedge link_clk) disable iff (!link_rst_n)
    bit_cnt_reg < LINK_LOAD_CNT |-> !link_sdo_oe)
    else $error("link driven during command bits");
  a_link_shift: assert property (@(posedge link_clk) disable iff (!link_rst_n)
    bit_cnt_reg > LINK_LOAD_CNT && bit_cnt_reg < LINK_LAST_CNT |=> link_sdo_oe == !$past(out_reg[14]))
    else $error("link word not shifted msb first");
endmodule // amr_top

// >>> hdl/amr_pkg.sv
// shared constants and types for the analog monitor readout
package amr_pkg;
  localparam int NUM_CH = 5;
  localparam int LIM_KINDS = 4;
  localparam int FLAG_STRIDE = 8;
  localparam int CTRL_FAULT_EN_BIT = 8;

  // channel order of the round robin, then the link status command
  localparam logic [2:0] CH_TEMP = 3'h0;
  localparam logic [2:0] CH_SUPPLY = 3'h1;
  localparam logic [2:0] CH_EXT_A = 3'h2;
  localparam logic [2:0] CH_EXT_B = 3'h3;
  localparam logic [2:0] CH_EXT_C = 3'h4;
  localparam logic [2:0] CMD_STATUS = 3'h5;

  // limit kinds
  localparam int K_ALARM_HI = 0;
  localparam int K_ALARM_LO = 1;
  localparam int K_WARN_HI = 2;
  localparam int K_WARN_LO = 3;

  // register byte offsets and the word transfer size
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DONE = 8'h04;
  localparam logic [7:0] ADDR_FLAGS = 8'h08;
  localparam logic [7:0] ADDR_RESULT_BASE = 8'h20;
  localparam logic [7:0] ADDR_LIMIT_BASE = 8'h40;
  localparam logic [7:0] ADDR_LIMIT_END = 8'h90;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // result format and limit reset values
  localparam logic [15:0] RESULT_MASK = 16'hFFF8;
  localparam logic [15:0] LIM_HI_UNS = 16'hFFFF;
  localparam logic [15:0] LIM_LO_UNS = 16'h0000;
  localparam logic [15:0] LIM_HI_SGN = 16'h7FFF;
  localparam logic [15:0] LIM_LO_SGN = 16'h8000;
  localparam int SUPPLY_LSB_NV = 100000;
  localparam int EXT_LSB_PV = 38147;

  // frame timing
  localparam int CLK_HZ = 10000000;
  localparam int FRAME_TYP_MS = 47;
  localparam int FRAME_MAX_MS = 60;
  localparam int FRAME_TYP_CYC = FRAME_TYP_MS * (CLK_HZ / 1000);
  localparam int FRAME_MAX_CYC = FRAME_MAX_MS * (CLK_HZ / 1000);

  // link bit counts
  localparam logic [4:0] LINK_LOAD_CNT = 5'h07;
  localparam logic [4:0] LINK_LAST_CNT = 5'h17;

  typedef struct packed {
    logic start;
    logic [2:0] chan;
  } amr_conv_req_t;

  typedef struct packed {
    logic done;
    logic [15:0] data;
  } amr_conv_rsp_t;
endpackage

// >>> verif/amr_link_host.sv
// host model for the serial result link
`timescale 1ns/1ns
module amr_link_host (
  // link pins
  output logic link_clk,
  output logic link_frame_n,
  output logic link_sdi,
  input wire logic link_sdo_oe
);
  logic [15:0] usable;

  initial begin
    link_clk = 1'b0;
    link_frame_n = 1'b1;
    link_sdi = 1'b1;
    usable = '0;
  end

  // one frame: command out msb first, word back msb first
  task automatic xfer(input logic [7:0] cmd, output logic [15:0] w);
    w = '0;
    link_frame_n = 1'b0;
    #37;
    for (int i = 1; i <= 24; i++) begin
      // unused command slot toggles so stale data is never seen
      link_sdi = (i <= 8) ? cmd[8 - i] : ~link_sdi;
      #15;
      // pull-up on the data line: low only while pulled
      if (i >= 9) begin
        w[24 - i] = ~link_sdo_oe;
      end
      link_clk = 1'b1;
      #15;
      link_clk = 1'b0;
    end
    link_frame_n = 1'b1;
    link_sdi = ~link_sdi;
    usable = w & 16'hFFF0;
    #100;
  endtask
endmodule // amr_link_host

// >>> verif/amr_top_tb.sv
// self-checking bench for the analog monitor readout
`timescale 1ns/1ns
module amr_top_tb;
  import amr_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = HSIZE_WORD;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  amr_conv_req_t conv_req;
  amr_conv_rsp_t conv_rsp = '0;
  logic in_a = 1'b1;
  logic in_b = 1'b1;
  logic oe_a;
  logic oe_b;
  logic irq;
  wire link_clk;
  wire link_frame_n;
  wire link_sdi;
  logic sdo_oe;
  int err_total = 0;
  int checked = 0;
  int cyc = 0;
  int last0 = 0;
  int rounds = 0;
  logic [2:0] nxt = 3'h0;
  logic [3:0] cw = '0;
  logic [2:0] cc = '0;
  logic [31:0] rd;
  logic [15:0] lw;
  logic [15:0] conv_val [5] = '{16'hF605, 16'h80FF, 16'hC00F, 16'h0007, 16'hFFFF};

  always #50 hclk = ~hclk;

  amr_top #(.FRAME_CYC(200)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .conv_req(conv_req), .conv_rsp(conv_rsp),
    .buffer_logic_input_a(in_a), .buffer_logic_input_b(in_b), .fault_buffer_output_a_oe(oe_a),
    .fault_buffer_output_b_oe(oe_b), .monitor_irq(irq), .link_clk(link_clk),
    .link_frame_n(link_frame_n), .link_sdi(link_sdi), .link_sdo_oe(sdo_oe));

  amr_link_host lh (.link_clk(link_clk), .link_frame_n(link_frame_n), .link_sdi(link_sdi),
    .link_sdo_oe(sdo_oe));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic fail(input string m);
    err_total++;
    $display("mismatch at %0t: %s", $time, m);
    report_and_stop();
  endtask

  // converter: latency grows with channel, data scrambled outside done
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    conv_rsp <= {1'b0, ~conv_rsp.data};
    if (cw != 4'h0) begin
      cw <= cw - 4'h1;
      if (cw == 4'h1) begin
        conv_rsp <= {1'b1, conv_val[cc]};
      end
    end
    if (conv_req.start === 1'b1) begin
      cw <= 4'h1 + 4'(conv_req.chan);
      cc <= conv_req.chan;
      chk(32'(conv_req.chan), 32'(nxt), "channel order");
      nxt <= (nxt == 3'h4) ? 3'h0 : nxt + 3'h1;
      if (conv_req.chan == 3'h0) begin
        if (last0 != 0) begin
          chk(cyc - last0, 200, "frame period");
        end
        last0 <= cyc;
        rounds <= rounds + 1;
      end
    end
  end

  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 40);
    if (hreadyout !== 1'b1) begin
      fail("bus hang");
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [2:0] sz = HSIZE_WORD);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= sz;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string m);
    ahb(1'b0, a, 32'h0);
    chk(rd, exp, m);
    chk(32'(hresp), 32'h0, "okay response");
  endtask

  // returns just after a whole round has been taken in
  task automatic wait_round();
    int r;
    int n;
    r = rounds;
    n = 0;
    while ((rounds == r || nxt != 3'h0 || cw != 4'h0) && n < 1000) begin
      @(posedge hclk);
      n++;
    end
    if (n >= 1000) begin
      fail("no round");
    end
    @(posedge hclk);
  endtask

  task automatic settle();
    repeat (4) @(posedge hclk);
  endtask

  task automatic t_regs();
    rchk(ADDR_CTRL, 32'h0, "ctrl reset");
    rchk(8'h40, 32'h7FFF, "temp hi reset");
    rchk(8'h44, 32'h8000, "temp lo reset");
    rchk(8'h50, 32'hFFFF, "supply hi reset");
    rchk(8'h8C, 32'h0, "ext c lo reset");
    ahb(1'b1, ADDR_CTRL, 32'h1F, 3'h1);
    rchk(ADDR_CTRL, 32'h0, "halfword ignored");
    ahb(1'b1, 8'h90, 32'hFFFF);
    rchk(8'h90, 32'h0, "unmapped");
  endtask

  task automatic t_conv();
    wait_round();
    for (int c = 0; c < NUM_CH; c++) begin
      rchk(8'h20 + 8'(4 * c), {16'h0, conv_val[c] & 16'hFFF8}, "result");
    end
    ahb(1'b1, 8'h24, 32'h0);
    rchk(8'h24, 32'h80F8, "result read only");
    rchk(ADDR_DONE, 32'h1F, "done set");
    ahb(1'b1, ADDR_DONE, 32'h1F);
    rchk(ADDR_DONE, 32'h0, "done cleared");
    wait_round();
    rchk(ADDR_DONE, 32'h1F, "done again");
  endtask

  task automatic t_limits();
    ahb(1'b1, 8'h50, 32'h80F0);
    ahb(1'b1, 8'h58, 32'h80F8);
    ahb(1'b1, 8'h40, 32'hF000);
    ahb(1'b1, 8'h4C, 32'h0);
    wait_round();
    rchk(ADDR_FLAGS, 32'h0100_0003, "flags");
    ahb(1'b1, ADDR_FLAGS, 32'h2);
    rchk(ADDR_FLAGS, 32'h0100_0003, "flag re-set");
    ahb(1'b1, 8'h50, 32'hFFFF);
    ahb(1'b1, ADDR_FLAGS, 32'h2);
    rchk(ADDR_FLAGS, 32'h0100_0001, "flag cleared");
  endtask

  task automatic t_pins();
    settle();
    chk(irq, 1'b0, "irq masked");
    chk(oe_a, 1'b0, "fault a idle");
    ahb(1'b1, ADDR_CTRL, 32'h1);
    settle();
    chk(irq, 1'b1, "irq enabled");
    ahb(1'b1, ADDR_CTRL, 32'h1E);
    settle();
    chk(irq, 1'b0, "irq other chans");
    ahb(1'b1, ADDR_CTRL, 32'h100);
    settle();
    chk(oe_a, 1'b1, "fault a alarm");
    ahb(1'b1, ADDR_CTRL, 32'h0);
    in_a <= 1'b0;
    in_b <= 1'b0;
    settle();
    chk({oe_a, oe_b}, 2'h3, "buffers low");
    in_a <= 1'b1;
    settle();
    chk({oe_a, oe_b}, 2'h1, "buffer a high");
    in_b <= 1'b1;
    settle();
    chk({oe_a, oe_b}, 2'h0, "buffers high");
  endtask

  task automatic t_link();
    lh.xfer(8'h01, lw);
    lh.xfer(8'h01, lw);
    chk(lw, 16'h80F8, "link supply");
    chk(lh.usable, 16'h80F0, "host usable bits");
    lh.xfer(8'h00, lw);
    chk(lw, 16'hF600, "link temp");
    lh.xfer(8'h04, lw);
    chk(lw, 16'hFFF8, "link ext c");
    lh.xfer(8'h05, lw);
    chk(lw, 16'h7C21, "link status");
    lh.xfer(8'h06, lw);
    chk(lw, 16'h0, "link bad cmd");
  endtask

  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_conv();
    t_limits();
    t_pins();
    t_link();
    report_and_stop();
  end

  initial begin
    #5_000_000;
    fail("watchdog");
  end
endmodule // amr_top_tb
